/* bsss_top.sv */
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "bsss_map.svh"

// Behaviour
// R1: hot standby only for modes 3 or 4
// R2: mode 3 returns below setpoint offset
// R3: mode 4 returns above setpoint offset
// R4: pilot on, main off after safety time
// R5: main on, pilot off after safety time
// R6: check gas pressure during hot standby
// R7: staging only on fuel 2
// R8: four stage outputs on fuel 2
// R9: nozzle 1 follows main valve output
// R10: three offsets, 2 to 50, default 5
// R11: nozzle count from cumulative offsets below setpoint
// R12: interpolation 1 to 9, default 7
// R13: operator enters ascending points on fuel 2
// R14: enter during commissioning adds next nozzle
// R15: low flame hold gives nozzle 1 only
// R16: hand mode gives all four nozzles
// R17: lockout/restart in commissioning resets controller
// R18: single point change on staging resets
// R19: channels 3/4 never servo, 6 not fuel 2
// R20: no air check, no trim on fuel 2
// R21: cumulative nozzles, updated every control update
module bsss_top #(
	parameter int MS_CYCLES = `BSSS_MS_PS / `BSSS_CLK_PERIOD_PS
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [15:0] measured_value,
	input wire logic [15:0] setpoint,
	input wire logic value_update,
	input wire logic burner_main_valve,
	input wire logic gas_pressure_low_pin,
	output logic pilot_valve,
	output logic main_valve,
	output logic [3:0] nozzle_out,
	output logic ratio_mod_enable,
	output logic air_check_enable,
	output logic exhaust_gas_trim_enable,
	output logic [5:0] servo_ch_enable,
	output logic gas_pressure_check,
	output logic controller_reset
);

	localparam logic [17:0] MS_LAST = 18'(MS_CYCLES - 1);

	// ****************************************************************
	// reset release
	// ****************************************************************
	logic rst_s1_reg;
	logic rst_n_sync; // reset used by the whole design

	// asserted at once, released after two clean edges
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_reg <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_sync <= rst_s1_reg;
		end
	end

	// ****************************************************************
	// bus front end
	// ****************************************************************
	logic rd_req;
	logic [7:0] rd_ofs;
	logic wr_req;
	logic [7:0] wr_ofs;

	bsss_ahb_slave u_bus (
		.clk(sys_clk),
		.rst_n(rst_n_sync),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hready(hready),
		.rd_req(rd_req),
		.rd_ofs(rd_ofs),
		.wr_req(wr_req),
		.wr_ofs(wr_ofs)
	);

	logic gas_low; // filtered pressure switch level

	bsss_sync3 u_gas_sync (
		.clk(sys_clk),
		.rst_n(rst_n_sync),
		.pin_in(gas_pressure_low_pin),
		.level_out(gas_low)
	);

	// ****************************************************************
	// software registers
	// ****************************************************************
	logic [2:0] mode_reg; // standby mode selection
	bsss_pkg::bsss_fuel_type fuel_reg;
	logic lfh_reg; // low flame hold
	logic hand_reg; // manual hand mode
	logic comm_reg; // commissioning active
	logic [7:0] sofs_reg [3]; // stage offsets 1..3
	logic [7:0] pilot_ofs_reg; // above setpoint to go to pilot
	logic [7:0] ret_ofs_reg; // offset for the return to main
	logic [15:0] safety_ms_reg; // second safety time in ms
	logic [3:0] interp_reg; // stage interpolation
	logic gas_fault_reg; // sticky: low gas in standby

	wire wr_ctrl = wr_req & (wr_ofs == `BSSS_CTRL_OFS);
	wire wr_offs = wr_req & (wr_ofs == `BSSS_OFFS_OFS);
	wire wr_stby = wr_req & (wr_ofs == `BSSS_STBY_OFS);
	wire wr_interp = wr_req & (wr_ofs == `BSSS_INTERP_OFS);
	wire wr_cmd = wr_req & (wr_ofs == `BSSS_CMD_OFS);

	// command strobes, one cycle each
	wire cmd_enter = wr_cmd & hwdata[`BSSS_CMD_ENTER_BIT];
	wire cmd_lockout = wr_cmd & hwdata[`BSSS_CMD_LOCKOUT_BIT];
	wire cmd_restart = wr_cmd & hwdata[`BSSS_CMD_RESTART_BIT];
	wire cmd_onept = wr_cmd & hwdata[`BSSS_CMD_ONEPT_BIT];
	wire cmd_gasclr = wr_cmd & hwdata[`BSSS_CMD_GASCLR_BIT];

	wire is_fuel2 = (fuel_reg == bsss_pkg::FUEL_2); // R7
	wire comm_f2 = comm_reg & is_fuel2;
	// a trip while commissioning fuel 2 behaves as a power-down
	wire comm_abort = comm_f2 & (cmd_lockout | cmd_restart); // R17
	wire onept_abort = is_fuel2 & cmd_onept; // R18

	// out-of-range writes are pulled to the nearest limit
	function automatic logic [7:0] clamp_ofs(input logic [7:0] v);
		if (v < `BSSS_STAGE_OFS_MIN) begin
			return `BSSS_STAGE_OFS_MIN;
		end else if (v > `BSSS_STAGE_OFS_MAX) begin
			return `BSSS_STAGE_OFS_MAX;
		end
		return v;
	endfunction

	function automatic logic [3:0] clamp_interp(input logic [3:0] v);
		if (v < `BSSS_INTERP_MIN) begin
			return `BSSS_INTERP_MIN;
		end else if (v > `BSSS_INTERP_MAX) begin
			return `BSSS_INTERP_MAX;
		end
		return v;
	endfunction

	// control selections; an abort drops commissioning
	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			mode_reg <= `BSSS_MODE_RST;
			fuel_reg <= bsss_pkg::FUEL_1;
			lfh_reg <= 1'b0;
			hand_reg <= 1'b0;
			comm_reg <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				mode_reg <= hwdata[`BSSS_CTRL_MODE_LSB +: 3];
				fuel_reg <= bsss_pkg::bsss_fuel_type'(hwdata[`BSSS_CTRL_FUEL_LSB +: 2]);
				lfh_reg <= hwdata[`BSSS_CTRL_LFH_BIT];
				hand_reg <= hwdata[`BSSS_CTRL_HAND_BIT];
				comm_reg <= hwdata[`BSSS_CTRL_COMM_BIT];
			end
			if (comm_abort) begin
				comm_reg <= 1'b0; // R17
			end
		end
	end

	// stage offsets, clamped to their legal span
	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			for (int i = 0; i < 3; i++) begin
				sofs_reg[i] <= `BSSS_STAGE_OFS_RST; // R10
			end
			interp_reg <= `BSSS_INTERP_RST; // R12
		end else begin
			if (wr_offs) begin
				for (int i = 0; i < 3; i++) begin
					sofs_reg[i] <= clamp_ofs(hwdata[8*i +: 8]); // R10
				end
			end
			if (wr_interp) begin
				interp_reg <= clamp_interp(hwdata[3:0]); // R12
			end
		end
	end

	// standby offsets and the second safety time
	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			pilot_ofs_reg <= `BSSS_PILOT_OFS_RST;
			ret_ofs_reg <= `BSSS_RETURN_OFS_RST;
			safety_ms_reg <= `BSSS_SAFETY_MS_RST;
		end else if (wr_stby) begin
			pilot_ofs_reg <= hwdata[7:0];
			ret_ofs_reg <= hwdata[15:8];
			safety_ms_reg <= hwdata[31:16];
		end
	end

	// ****************************************************************
	// hot standby sequence
	// ****************************************************************
	bsss_pkg::bsss_stby_state_type st_reg;
	bsss_pkg::bsss_stby_state_type st_next;
	logic [17:0] ms_cnt_reg; // cycles within the current ms
	logic [15:0] safe_cnt_reg; // whole ms spent in the overlap

	wire stby_en = (mode_reg == `BSSS_MODE_HOT_BELOW) | (mode_reg == `BSSS_MODE_HOT_ABOVE); // R1
	wire signed [17:0] excess = $signed({2'b00, measured_value}) - $signed({2'b00, setpoint});
	wire signed [17:0] pilot_lim = $signed({10'h000, pilot_ofs_reg});
	wire signed [17:0] ret_lim = $signed({10'h000, ret_ofs_reg});
	wire go_pilot = (excess >= pilot_lim); // R2 R3
	// mode 3 waits below setpoint, mode 4 may return above it
	wire go_main = (mode_reg == `BSSS_MODE_HOT_BELOW) ? (excess <= -ret_lim) : // R2
		(excess <= ret_lim); // R3
	wire overlap = (st_reg == bsss_pkg::ST_TO_PILOT) | (st_reg == bsss_pkg::ST_TO_MAIN);
	wire ms_tick = (ms_cnt_reg == MS_LAST);
	wire safety_done = (safe_cnt_reg >= safety_ms_reg);

	// next state of the pilot/main swap
	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			bsss_pkg::ST_MAIN: begin
				if (stby_en & burner_main_valve & go_pilot) begin
					st_next = bsss_pkg::ST_TO_PILOT; // R1
				end
			end
			bsss_pkg::ST_TO_PILOT: begin
				if (safety_done) begin
					st_next = bsss_pkg::ST_PILOT; // R4
				end
			end
			bsss_pkg::ST_PILOT: begin
				// a mode change away from standby also brings main back
				if (go_main | ~stby_en) begin
					st_next = bsss_pkg::ST_TO_MAIN;
				end
			end
			bsss_pkg::ST_TO_MAIN: begin
				if (safety_done) begin
					st_next = bsss_pkg::ST_MAIN; // R5
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			st_reg <= bsss_pkg::ST_MAIN;
		end else begin
			st_reg <= st_next;
		end
	end

	// overlap timer; the ms prescaler keeps the counter narrow
	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			ms_cnt_reg <= 18'h00000;
			safe_cnt_reg <= 16'h0000;
		end else if (!overlap || st_next != st_reg) begin
			ms_cnt_reg <= 18'h00000;
			safe_cnt_reg <= 16'h0000;
		end else begin
			ms_cnt_reg <= ms_tick ? 18'h00000 : ms_cnt_reg + 18'h00001;
			if (ms_tick && !safety_done) begin
				safe_cnt_reg <= safe_cnt_reg + 16'h0001; // R4 R5
			end
		end
	end

	// pilot held open during both overlaps; main kept through them
	wire pilot_next = (st_next != bsss_pkg::ST_MAIN); // R4 R5
	wire main_next = burner_main_valve & (st_next != bsss_pkg::ST_PILOT); // R4 R5

	// low gas while on pilot is latched; the latch wins over a clear
	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			gas_fault_reg <= 1'b0;
		end else if (st_reg == bsss_pkg::ST_PILOT && gas_low) begin
			gas_fault_reg <= 1'b1; // R6
		end else if (cmd_gasclr) begin
			gas_fault_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// staged nozzles on fuel 2
	// ****************************************************************
	logic [2:0] stage_reg; // stages 2..4 demanded by load
	logic [2:0] comm_cnt_reg; // nozzles set so far in commissioning
	logic [2:0] stage_chain; // cumulative view of stage_reg
	logic [2:0] noz_cnt; // nozzles wanted, 0..4
	wire signed [17:0] deficit = -excess;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_stage
			// cumulative threshold and its drop-out margin
			logic [9:0] thr;
			logic [11:0] prod;
			logic [9:0] hyst;
			if (g == 0) begin : g_t0
				assign thr = {2'b00, sofs_reg[0]};
			end else begin : g_tn
				assign thr = g_stage[g-1].thr + {2'b00, sofs_reg[g]}; // R11
			end
			// high interpolation keeps the switch-on point but drops out sooner
			assign prod = sofs_reg[g] * (4'h9 - interp_reg + 4'h1); // R12
			assign hyst = {2'b00, prod[11:4]};
			wire on_hit = deficit >= $signed({8'h00, thr}); // R11
			wire off_hit = deficit < $signed({8'h00, thr - hyst});
			// thresholds ascend, so lower stages always sit below
			if (g == 0) begin : g_c0
				assign stage_chain[g] = stage_reg[g];
			end else begin : g_cn
				assign stage_chain[g] = stage_reg[g] & stage_chain[g-1]; // R21
			end
			// re-evaluated on each control update only
			always_ff @(posedge sys_clk or negedge rst_n_sync) begin
				if (!rst_n_sync) begin
					stage_reg[g] <= 1'b0;
				end else if (value_update) begin
					if (on_hit) begin
						stage_reg[g] <= 1'b1; // R21
					end else if (off_hit) begin
						stage_reg[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// each enter while commissioning fuel 2 opens the next nozzle, up to the fourth
	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			comm_cnt_reg <= 3'h1;
		end else if (!comm_f2 || comm_abort) begin
			comm_cnt_reg <= 3'h1; // R17
		end else if (cmd_enter && comm_cnt_reg != 3'h4) begin
			comm_cnt_reg <= comm_cnt_reg + 3'h1; // R14
		end
	end

	// nozzle demand by priority: hand, low flame, commissioning, load
	always_comb begin
		if (!is_fuel2) begin
			noz_cnt = 3'h0; // R7
		end else if (hand_reg) begin
			noz_cnt = 3'h4; // R16
		end else if (lfh_reg) begin
			noz_cnt = 3'h1; // R15
		end else if (comm_reg) begin
			noz_cnt = comm_cnt_reg; // R14
		end else begin
			noz_cnt = 3'h1 + {2'b00, stage_chain[0]} + {2'b00, stage_chain[1]}
				+ {2'b00, stage_chain[2]}; // R11 R21
		end
	end

	// nozzles ride on the main valve signal, lowest first
	logic [3:0] noz_next;
	generate
		for (g = 0; g < 4; g++) begin : g_noz
			assign noz_next[g] = main_next & (noz_cnt > 3'(g)); // R8 R9 R21
		end
	endgenerate

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	// chan 1,2 always; 3,4 are staging neutrals; 6 not on fuel 2
	wire [5:0] servo_next = {~is_fuel2, 1'b1, 2'b00, 2'b11}; // R19

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			pilot_valve <= 1'b0;
			main_valve <= 1'b0;
			nozzle_out <= 4'h0;
			gas_pressure_check <= 1'b0;
			controller_reset <= 1'b0;
		end else begin
			pilot_valve <= pilot_next; // R4 R5
			main_valve <= main_next; // R4 R5
			nozzle_out <= noz_next; // R8 R9
			gas_pressure_check <= (st_next == bsss_pkg::ST_PILOT); // R6
			controller_reset <= comm_abort | onept_abort; // R17 R18
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			ratio_mod_enable <= 1'b1;
			air_check_enable <= 1'b1;
			exhaust_gas_trim_enable <= 1'b1;
			servo_ch_enable <= 6'h33;
		end else begin
			ratio_mod_enable <= ~is_fuel2; // R7
			air_check_enable <= ~is_fuel2; // R20
			exhaust_gas_trim_enable <= ~is_fuel2; // R20
			servo_ch_enable <= servo_next; // R19
		end
	end

	// ****************************************************************
	// read path, registered for the data phase
	// ****************************************************************
	wire [31:0] rd_ctrl = {23'h000000, comm_reg, hand_reg, lfh_reg, fuel_reg, 1'b0, mode_reg};
	wire [31:0] rd_offs = {8'h00, sofs_reg[2], sofs_reg[1], sofs_reg[0]};
	wire [31:0] rd_stby = {safety_ms_reg, ret_ofs_reg, pilot_ofs_reg};
	wire [31:0] rd_stat = {17'h00000, comm_cnt_reg, gas_fault_reg, stage_chain,
		nozzle_out, main_valve, pilot_valve, st_reg};
	logic [31:0] rd_mux;

	// unmapped and command addresses read zero
	always_comb begin
		unique case (rd_ofs)
			`BSSS_CTRL_OFS: rd_mux = rd_ctrl;
			`BSSS_OFFS_OFS: rd_mux = rd_offs;
			`BSSS_STBY_OFS: rd_mux = rd_stby;
			`BSSS_INTERP_OFS: rd_mux = {28'h0000000, interp_reg};
			`BSSS_STAT_OFS: rd_mux = rd_stat;
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			if (rd_req) begin
				hrdata <= rd_mux;
			end
			hreadyout <= 1'b1; // never waits
			hresp <= 1'b0; // always okay
		end
	end

endmodule

/* bsss_map.svh */
`ifndef BSSS_MAP_SVH
`define BSSS_MAP_SVH

// ****************************************************************
// register byte offsets (low address byte)
// ****************************************************************
`define BSSS_CTRL_OFS 8'h00
`define BSSS_OFFS_OFS 8'h04
`define BSSS_STBY_OFS 8'h08
`define BSSS_INTERP_OFS 8'h0c
`define BSSS_CMD_OFS 8'h10
`define BSSS_STAT_OFS 8'h14

// ****************************************************************
// field positions
// ****************************************************************
`define BSSS_CTRL_MODE_LSB 0
`define BSSS_CTRL_FUEL_LSB 4
`define BSSS_CTRL_LFH_BIT 6
`define BSSS_CTRL_HAND_BIT 7
`define BSSS_CTRL_COMM_BIT 8
`define BSSS_CMD_ENTER_BIT 0
`define BSSS_CMD_LOCKOUT_BIT 1
`define BSSS_CMD_RESTART_BIT 2
`define BSSS_CMD_ONEPT_BIT 3
`define BSSS_CMD_GASCLR_BIT 4

// ****************************************************************
// reset values and limits
// ****************************************************************
`define BSSS_MODE_RST 3'h0
`define BSSS_MODE_HOT_BELOW 3'h3
`define BSSS_MODE_HOT_ABOVE 3'h4
`define BSSS_STAGE_OFS_RST 8'h05
`define BSSS_STAGE_OFS_MIN 8'h02
`define BSSS_STAGE_OFS_MAX 8'h32
`define BSSS_INTERP_RST 4'h7
`define BSSS_INTERP_MIN 4'h1
`define BSSS_INTERP_MAX 4'h9
`define BSSS_PILOT_OFS_RST 8'h05
`define BSSS_RETURN_OFS_RST 8'h05
`define BSSS_SAFETY_MS_RST 16'h0bb8

// ****************************************************************
// timing
// ****************************************************************
`define BSSS_CLK_PERIOD_PS 4000
`define BSSS_MS_PS 1000000000

`endif

/* bsss_pkg.sv */
package bsss_pkg;

	// hot standby sequence, gray along main -> pilot -> main
	typedef enum logic [1:0] {
		ST_MAIN = 2'h0,
		ST_TO_PILOT = 2'h1,
		ST_PILOT = 2'h3,
		ST_TO_MAIN = 2'h2
	} bsss_stby_state_type;

	// selected fuel
	typedef enum logic [1:0] {
		FUEL_1 = 2'h0,
		FUEL_2 = 2'h1,
		FUEL_3 = 2'h2,
		FUEL_4 = 2'h3
	} bsss_fuel_type;

endpackage

/* bsss_sync3.sv */
`timescale 1ns/1ps

// ****************************************************************
// three-stage pin synchroniser with agreement filter
// ****************************************************************
module bsss_sync3 (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin_in,
	output logic level_out
);

	logic s1_reg; // metastable stage, read only by s2
	logic s2_reg;
	logic s3_reg;

	// output follows only once the last two stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_out <= 1'b0;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level_out <= s3_reg;
			end
		end
	end

endmodule

/* bsss_ahb_slave.sv */
`timescale 1ns/1ps

// ****************************************************************
// ahb-lite address/data phase tracker, zero wait states
// ****************************************************************
module bsss_ahb_slave (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	output logic rd_req,
	output logic [7:0] rd_ofs,
	output logic wr_req,
	output logic [7:0] wr_ofs
);

	logic wr_pend_reg; // write accepted, data phase follows
	logic [7:0] wr_ofs_reg;
	logic xfer;

	// a transfer is taken when selected, active and the bus is ready
	assign xfer = hsel & htrans[1] & hready;
	assign rd_req = xfer & ~hwrite;
	assign rd_ofs = {haddr[7:2], 2'b00};
	assign wr_req = wr_pend_reg;
	assign wr_ofs = wr_ofs_reg;

	// remember a write until its data phase; hwdata is used then
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_reg <= 1'b0;
			wr_ofs_reg <= 8'h00;
		end else begin
			wr_pend_reg <= xfer & hwrite;
			wr_ofs_reg <= {haddr[7:2], 2'b00};
		end
	end

endmodule

/* bsss_top_properties.sv */
`timescale 1ns/1ps
// ****
// port relations of the sequencer
// ****
module bsss_top_chk (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic burner_main_valve,
	input wire logic pilot_valve,
	input wire logic main_valve,
	input wire logic [3:0] nozzle_out,
	input wire logic ratio_mod_enable,
	input wire logic air_check_enable,
	input wire logic exhaust_gas_trim_enable,
	input wire logic [5:0] servo_ch_enable,
	input wire logic gas_pressure_check,
	input wire logic controller_reset
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// main closes although the sequence still asks for it: a pilot swap
	sequence s_main_drop;
		$fell(main_valve) && $past(burner_main_valve);
	endsequence
	// pilot closes at the end of the return overlap
	sequence s_pilot_drop;
		$fell(pilot_valve) && $past(burner_main_valve);
	endsequence
	property p_pilot_first;
		s_main_drop |-> pilot_valve;
	endproperty
	a_pilot_first: assert property (p_pilot_first) else $error("main shut, no pilot");
	property p_main_first;
		s_pilot_drop |-> main_valve;
	endproperty
	a_main_first: assert property (p_main_first) else $error("pilot shut, no main");
	property p_gas;
		gas_pressure_check |-> pilot_valve && !main_valve;
	endproperty
	a_gas: assert property (p_gas) else $error("gas check outside pilot");
	property p_flags;
		ratio_mod_enable == air_check_enable && air_check_enable == exhaust_gas_trim_enable;
	endproperty
	a_flags: assert property (p_flags) else $error("fuel flags disagree");
	property p_servo;
		servo_ch_enable[4:0] == 5'h13 && servo_ch_enable[5] == ratio_mod_enable;
	endproperty
	a_servo: assert property (p_servo) else $error("servo channel map");
	property p_cumul;
		nozzle_out inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
	endproperty
	a_cumul: assert property (p_cumul) else $error("nozzle gap");
	// nozzle 1 rides on the main valve, allow one edge of skew
	property p_nz_main;
		nozzle_out[0] |-> main_valve || $past(main_valve);
	endproperty
	a_nz_main: assert property (p_nz_main) else $error("nozzle 1 without main");
	property p_nz_fuel;
		|nozzle_out |-> !ratio_mod_enable || !$past(ratio_mod_enable);
	endproperty
	a_nz_fuel: assert property (p_nz_fuel) else $error("nozzles off fuel 2");
	property p_rst_pulse;
		controller_reset |=> !controller_reset;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
endmodule
bind bsss_top bsss_top_chk bsss_top_chk_i (.sys_clk, .arst_n, .burner_main_valve,
	.pilot_valve, .main_valve, .nozzle_out, .ratio_mod_enable, .air_check_enable,
	.exhaust_gas_trim_enable, .servo_ch_enable, .gas_pressure_check, .controller_reset);

/* bsss_valve_model.sv */
`timescale 1ns/1ps
// ****
// valves, nozzle solenoids and gas sensor
// ****
module bsss_valve_model (
	input wire logic pilot_valve,
	input wire logic main_valve,
	input wire logic [3:0] nozzle_out,
	input wire logic gas_low_req,
	output logic gas_pressure_low_pin,
	output int open_count
);
	// the measuring pipe only loses pressure while the pilot fires alone
	assign gas_pressure_low_pin = gas_low_req & pilot_valve & ~main_valve;
	// solenoids open, for the bench to watch
	assign open_count = $countones(nozzle_out);
endmodule

/* tb_bsss.sv */
`timescale 1ns/1ps
`include "bsss_map.svh"
module tb_burner_standby_and_staging_sequencer;
	logic sys_clk = 0;
	logic arst_n = 0;
	logic hsel = 0;
	logic [31:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic hwrite = 0;
	logic [31:0] hwdata = 0;
	logic [15:0] measured_value = 16'h03e8;
	logic [15:0] setpoint = 16'h03e8;
	logic value_update = 0;
	logic burner_main_valve = 0;
	logic gas_low_req = 0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, gas_pin, pilot_valve, main_valve, gas_pressure_check;
	logic ratio_mod_enable, controller_reset;
	logic [3:0] nozzle_out;
	logic [5:0] servo_ch_enable;
	int err_count = 0;
	int compares = 0;
	int pulses = 0;
	int open_count, n, d, b;
	int q[$];
	// ****
	// clock, update pulses, pulse counter
	// ****
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) value_update <= ~value_update;
	always @(posedge sys_clk) if (controller_reset === 1'b1) pulses++;
	bsss_top #(.MS_CYCLES(4)) bsss_top_i (.sys_clk, .arst_n, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.measured_value, .setpoint, .value_update, .burner_main_valve,
		.gas_pressure_low_pin(gas_pin), .pilot_valve, .main_valve, .nozzle_out,
		.ratio_mod_enable, .air_check_enable(), .exhaust_gas_trim_enable(),
		.servo_ch_enable, .gas_pressure_check, .controller_reset);
	bsss_valve_model bsss_valve_model_i (.pilot_valve, .main_valve, .nozzle_out,
		.gas_low_req, .gas_pressure_low_pin(gas_pin), .open_count);
	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	// bounded wait for a level; running out ends the run
	task automatic wait_for(ref logic s, input logic v, output int k);
		k = 0;
		while (s !== v && k < 200) begin
			@(posedge sys_clk);
			k++;
		end
		if (k >= 200) begin
			err_count++;
			tally_and_finish;
		end
	endtask
	// one single transfer, address phase then data phase; ready is judged at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge sys_clk);
		wait_for(hreadyout, 1'b1, n);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge sys_clk);
		wait_for(hreadyout, 1'b1, n);
		rd = hrdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
		chk(hresp, 1'b0);
	endtask
	// bench model of the nozzle count from the deficit below setpoint
	function automatic logic [3:0] stage_exp(input int dd);
		int c;
		c = 1 + (dd >= 5) + (dd >= 10) + (dd >= 15);
		return 4'((1 << c) - 1);
	endfunction
	// pilot swap out and back for one standby mode
	task automatic stby(input int mode, input int back);
		bus(1'b1, `BSSS_CTRL_OFS, mode);
		measured_value <= 16'h03f2;
		wait_for(pilot_valve, 1'b1, n);
		wait_for(main_valve, 1'b0, n);
		chk(n >= 7 && n <= 9, 1);
		chk(gas_pressure_check, 1);
		measured_value <= 16'h03ee;
		gas_low_req <= 1'b1;
		cyc(20);
		chk(main_valve, 0);
		bus(1'b0, `BSSS_STAT_OFS, 0);
		chk(rd[11:0], 12'h807);
		gas_low_req <= 1'b0;
		cyc(10);
		bus(1'b1, `BSSS_CMD_OFS, 32'h10);
		bus(1'b0, `BSSS_STAT_OFS, 0);
		chk(rd[11], 1'b0);
		measured_value <= 16'(1000 + back);
		wait_for(main_valve, 1'b1, n);
		wait_for(pilot_valve, 1'b0, n);
		chk(n >= 7 && n <= 9, 1);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		void'($urandom(32'h0d61));
		cyc(3);
		arst_n <= 1'b1;
		burner_main_valve <= 1'b1;
		cyc(2);
		rdc(`BSSS_OFFS_OFS, 32'h00050505);
		rdc(`BSSS_STBY_OFS, 32'h0bb80505);
		rdc(`BSSS_INTERP_OFS, 32'h7);
		rdc(8'h18, 32'h0);
		bus(1'b1, `BSSS_OFFS_OFS, 32'h00ff3301);
		rdc(`BSSS_OFFS_OFS, 32'h00323202);
		bus(1'b1, `BSSS_INTERP_OFS, 32'h0);
		rdc(`BSSS_INTERP_OFS, 32'h1);
		bus(1'b1, `BSSS_INTERP_OFS, 32'ha);
		rdc(`BSSS_INTERP_OFS, 32'h9);
		bus(1'b1, `BSSS_INTERP_OFS, 32'h7);
		bus(1'b1, `BSSS_OFFS_OFS, 32'h00050505);
		$display("registers done");
		for (int f = 0; f < 4; f++) begin
			bus(1'b1, `BSSS_CTRL_OFS, f << 4);
			cyc(4);
			chk(ratio_mod_enable, f != 1);
			chk(servo_ch_enable, {f != 1, 5'h13});
			chk(nozzle_out, f == 1);
		end
		$display("fuels done");
		bus(1'b1, `BSSS_CTRL_OFS, 32'h10);
		for (int i = 0; i < 10; i++) begin
			d = $urandom_range(19, 0);
			measured_value <= 16'(1000 - d);
			cyc(6);
			chk(nozzle_out, stage_exp(d));
		end
		// interpolation 1 widens the drop-out margin of stage 2 to 2
		bus(1'b1, `BSSS_INTERP_OFS, 32'h1);
		measured_value <= 16'h03e3;
		cyc(6);
		measured_value <= 16'h03e4;
		cyc(6);
		chk(nozzle_out, 4'h3);
		bus(1'b1, `BSSS_CTRL_OFS, 32'h50);
		cyc(4);
		chk(nozzle_out, 4'h1);
		bus(1'b1, `BSSS_CTRL_OFS, 32'h90);
		cyc(4);
		chk(nozzle_out, 4'hf);
		chk(open_count, 4);
		measured_value <= 16'h03e8;
		bus(1'b1, `BSSS_CTRL_OFS, 32'h110);
		q = '{4'h3, 4'h7, 4'hf, 4'hf};
		foreach (q[i]) begin
			bus(1'b1, `BSSS_CMD_OFS, 32'h1);
			cyc(4);
			chk(nozzle_out, q[i]);
		end
		$display("staging done");
		for (int c = 1; c < 4; c++) begin
			bus(1'b1, `BSSS_CTRL_OFS, 32'h110);
			b = pulses;
			bus(1'b1, `BSSS_CMD_OFS, 1 << c);
			cyc(4);
			chk(pulses, b + 1);
			rdc(`BSSS_CTRL_OFS, c == 3 ? 32'h110 : 32'h10);
		end
		bus(1'b1, `BSSS_CTRL_OFS, 32'h0);
		b = pulses;
		bus(1'b1, `BSSS_CMD_OFS, 32'h8);
		cyc(4);
		chk(pulses, b);
		$display("resets done");
		bus(1'b1, `BSSS_STBY_OFS, 32'h0002050a);
		measured_value <= 16'h03fc;
		cyc(30);
		chk(pilot_valve, 0);
		stby(3, -5);
		stby(4, 5);
		$display("standby done");
		tally_and_finish;
	end
endmodule
